//--- sog_cfg.svh
// register offsets, reset values, field positions and ramp constants for the output stage
`ifndef SOG_CFG_SVH
`define SOG_CFG_SVH
`define SOG_IDX_SYNTH_EN 12'h308
`define SOG_IDX_RAMP_LEN 12'h330
`define SOG_IDX_OUT_CFG 12'h331
`define SOG_IDX_GAIN_A 12'h332
`define SOG_IDX_TX_CTRL 12'h338
`define SOG_IDX_STATUS 12'h339
`define SOG_RST_SYNTH_EN 1'h0
`define SOG_RST_RAMP_LEN 3'h0
`define SOG_RST_OUT_CFG 2'h2
`define SOG_RST_GAIN_A 16'h0003
`define SOG_RST_TX_CTRL 2'h0
`define SOG_BIT_COMBINE 0
`define SOG_BIT_DITHER 1
`define SOG_DITHER_BACKOFF 17'h00010
`define SOG_GAIN_UNITY 17'h10000
`define SOG_RAMP_FULL 11'h400
`define SOG_RAMP_STEP_MAX_LOG 3'h7
`define SOG_ROUND_HALF 4'h8
`define SOG_LFSR_SEED 16'hACE1
`endif

//--- sog_pkg.sv
// types shared by the synthesizer output stage
package sog_pkg;
	typedef logic signed [15:0] sog_sample_type;
	typedef logic [11:0] sog_dac_word_type;
	typedef logic [10:0] sog_ramp_type;
endpackage : sog_pkg

//--- sog_output_stage.sv
// synthesizer output stage: ramp, combine, gain backoff, dither, output fifo and apb registers
//
// Functional notes
// - transmit on ramps up, off ramps down
// - dither bit adds sub-LSB dither before rounding
// - combine clear keeps oscillators independent
// - combine set sums oscillators into both channels
// - oscillator A gain is one minus backoff/65536
// - dither adds extra backoff under programmed backoff
// - oscillator A gain clamps at zero
// - backoff resets to three
// - synthesizer enable clear holds stage in reset
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "sog_cfg.svh"

module sog_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	// depth must be a power of two so the pointers wrap on their own
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic ready_q;
	logic valid_q;

	wire push = in_valid && ready_q;
	wire pop = out_ready && valid_q;

	assign count_d = flush ? '0 : count_q + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready = ready_q;
	assign out_valid = valid_q;
	assign out_data = mem[rd_q];

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			ready_q <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			wr_q <= flush ? '0 : wr_q + AW'(push);
			rd_q <= flush ? '0 : rd_q + AW'(pop);
			count_q <= count_d;
			// flags registered from the next count so both ports see flop outputs
			ready_q <= count_d != DEPTH_CNT;
			valid_q <= count_d != '0;
		end
	end
endmodule : sog_fifo

module sog_output_stage #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [1:0] transmit_enable,
	input wire sog_pkg::sog_sample_type osc_a_sample,
	input wire sog_pkg::sog_sample_type osc_b_sample,
	input wire logic osc_valid,
	output logic osc_ready,
	output logic out_valid,
	output sog_pkg::sog_dac_word_type converter_chan_a,
	output sog_pkg::sog_dac_word_type converter_chan_b,
	input wire logic out_ready
);
	import sog_pkg::*;

	// registers
	logic synth_en_q;
	logic [2:0] ramp_length_code_q;
	logic [1:0] out_cfg_q;
	logic [15:0] gain_backoff_q;
	logic [1:0] tx_reg_q;
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [1:0] tx_meta_q;
	logic [1:0] tx_sync_q;
	logic [15:0] lfsr_q;
	sog_ramp_type ramp_q [2];
	logic out_valid_q;
	sog_dac_word_type chan_a_q;
	sog_dac_word_type chan_b_q;

	// apb decode
	wire [11:0] idx = paddr[13:2];
	wire in_range = paddr[15:14] == 2'h0;
	wire hit_en = in_range && idx == `SOG_IDX_SYNTH_EN;
	wire hit_ramp = in_range && idx == `SOG_IDX_RAMP_LEN;
	wire hit_cfg = in_range && idx == `SOG_IDX_OUT_CFG;
	wire hit_gain = in_range && idx == `SOG_IDX_GAIN_A;
	wire hit_tx = in_range && idx == `SOG_IDX_TX_CTRL;
	wire hit_stat = in_range && idx == `SOG_IDX_STATUS;
	wire mapped = hit_en || hit_ramp || hit_cfg || hit_gain || hit_tx || hit_stat;
	wire setup = psel && !penable;
	wire wr_ok = psel && penable && pready_q && pwrite && mapped;

	wire combine = out_cfg_q[`SOG_BIT_COMBINE];
	wire dither_enable = out_cfg_q[`SOG_BIT_DITHER];
	wire osc_a_dither_enable = dither_enable;
	wire [1:0] tx_on = tx_sync_q | tx_reg_q;

	wire [31:0] rd_mux =
		hit_en ? {31'h0, synth_en_q} :
		hit_ramp ? {29'h0, ramp_length_code_q} :
		hit_cfg ? {30'h0, out_cfg_q} :
		hit_gain ? {16'h0, gain_backoff_q} :
		hit_tx ? {30'h0, tx_reg_q} :
		hit_stat ? {8'h0, tx_on, ramp_q[1], ramp_q[0]} : 32'h0;

	// oscillator A gain path
	wire [16:0] backoff_total = {1'b0, gain_backoff_q}
		+ (osc_a_dither_enable ? `SOG_DITHER_BACKOFF : 17'h0);
	// totals of full scale or more leave bit 16 set and give zero gain
	wire [16:0] gain_a = backoff_total[16] ? 17'h0 : `SOG_GAIN_UNITY - backoff_total;
	wire signed [33:0] a_prod = osc_a_sample * $signed({1'b0, gain_a});
	wire signed [15:0] a_gained = a_prod[31:16];

	wire signed [15:0] src [2];
	wire signed [15:0] ramped [2];
	wire signed [15:0] chan_val [2];
	sog_dac_word_type chan_word [2];
	assign src[0] = a_gained;
	assign src[1] = osc_b_sample;

	wire signed [16:0] sum_wide = 17'(ramped[0]) + 17'(ramped[1]);
	wire signed [15:0] sum_sat = (sum_wide > 17'sh07FFF) ? 16'sh7FFF :
		(sum_wide < -17'sh08000) ? -16'sh8000 : sum_wide[15:0];
	assign chan_val[0] = combine ? sum_sat : ramped[0];
	assign chan_val[1] = combine ? sum_sat : ramped[1];

	// ramp step per clock: full scale over 16 << (code - 1) cycles
	wire [2:0] step_log = `SOG_RAMP_STEP_MAX_LOG - ramp_length_code_q;
	wire [10:0] step = 11'h001 << step_log;

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_chan
			sog_ramp_type ramp_d;
			wire signed [27:0] prod;
			wire [3:0] round_bits;
			wire signed [16:0] rounded;
			wire signed [12:0] shifted;

			// moving from the current value toward the target reverses a ramp in flight
			assign ramp_d = !synth_en_q ? 11'h000 :
				(ramp_length_code_q == 3'h0) ? (tx_on[i] ? `SOG_RAMP_FULL : 11'h000) :
				tx_on[i] ? ((ramp_q[i] > `SOG_RAMP_FULL - step) ? `SOG_RAMP_FULL : ramp_q[i] + step) :
				((ramp_q[i] < step) ? 11'h000 : ramp_q[i] - step);

			assign prod = src[i] * $signed({1'b0, ramp_q[i]});
			assign ramped[i] = prod[25:10];

			// dither fills the four bits dropped by rounding; otherwise round half up
			// summed channels share one dither draw so both words stay identical
			assign round_bits = dither_enable ? lfsr_q[(combine ? 0 : 4*i) +: 4] : `SOG_ROUND_HALF;
			assign rounded = 17'(chan_val[i]) + 17'($signed({1'b0, round_bits}));
			assign shifted = rounded[16:4];
			assign chan_word[i] = (shifted > 13'sh07FF) ? 12'h7FF :
				(shifted < -13'sh0800) ? 12'h800 : shifted[11:0];

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ramp_q[i] <= 11'h000;
				end
				else
				begin
					ramp_q[i] <= ramp_d;
				end
			end
		end
	endgenerate

	// output fifo carries both converter words together
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [23:0] fifo_out_data;
	wire out_take = !out_valid_q || out_ready;

	sog_fifo #(
		.WIDTH(24),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.flush(!synth_en_q),
		.in_valid(osc_valid && synth_en_q),
		.in_data({chan_word[1], chan_word[0]}),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(out_take)
	);

	assign osc_ready = fifo_in_ready;
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign out_valid = out_valid_q;
	assign converter_chan_a = chan_a_q;
	assign converter_chan_b = chan_b_q;

	// apb answers one cycle after setup, so the access phase is never stretched
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= setup;
			prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0;
			pslverr_q <= setup && !mapped;
		end
	end

	// software registers keep their values while the stage is held in reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			synth_en_q <= `SOG_RST_SYNTH_EN;
			ramp_length_code_q <= `SOG_RST_RAMP_LEN;
			out_cfg_q <= `SOG_RST_OUT_CFG;
			gain_backoff_q <= `SOG_RST_GAIN_A;
			tx_reg_q <= `SOG_RST_TX_CTRL;
		end
		else if (wr_ok)
		begin
			if (hit_en)
				synth_en_q <= pwdata[0];
			if (hit_ramp)
				ramp_length_code_q <= pwdata[2:0];
			if (hit_cfg)
				out_cfg_q <= pwdata[1:0];
			if (hit_gain)
				gain_backoff_q <= pwdata[15:0];
			if (hit_tx)
				tx_reg_q <= pwdata[1:0];
		end
	end

	// transmit enable pins are asynchronous to the sample clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_meta_q <= 2'h0;
			tx_sync_q <= 2'h0;
		end
		else
		begin
			tx_meta_q <= transmit_enable;
			tx_sync_q <= tx_meta_q;
		end
	end

	// dither source; reseeded while disabled so each start repeats the same sequence
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lfsr_q <= `SOG_LFSR_SEED;
		end
		else if (!synth_en_q)
		begin
			lfsr_q <= `SOG_LFSR_SEED;
		end
		else
		begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		end
	end

	// output register keeps the converter ports on flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_valid_q <= 1'b0;
			chan_a_q <= 12'h000;
			chan_b_q <= 12'h000;
		end
		else if (!synth_en_q)
		begin
			out_valid_q <= 1'b0;
			chan_a_q <= 12'h000;
			chan_b_q <= 12'h000;
		end
		else if (out_take)
		begin
			out_valid_q <= fifo_out_valid;
			chan_a_q <= fifo_out_data[11:0];
			chan_b_q <= fifo_out_data[23:12];
		end
	end
endmodule : sog_output_stage

//--- sog_output_stage_properties.sv
// port-level checks for the synthesizer output stage
`timescale 1ns/1ps
module sog_output_stage_properties #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic osc_valid,
	input wire logic osc_ready,
	input wire logic out_valid,
	input wire sog_pkg::sog_dac_word_type converter_chan_a,
	input wire sog_pkg::sog_dac_word_type converter_chan_b,
	input wire logic out_ready
);
	import sog_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic en_q;
	logic comb_q;
	wire wr_done = psel && penable && pready && pwrite;
	// shadow copies of enable and combine, taken at the same edge the slave commits
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			en_q <= 1'b0;
		else if (wr_done && paddr == 16'hC20)
			en_q <= pwdata[0];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			comb_q <= 1'b0;
		else if (wr_done && paddr == 16'hCC4)
			comb_q <= pwdata[0];
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	property p_ready_answer;
		psel && !penable |=> pready;
	endproperty
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	property p_rdata_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	property p_unmapped;
		pready && paddr == 16'h0004 |-> pslverr;
	endproperty
	property p_out_hold;
		out_valid && !out_ready |=> out_valid && $stable(converter_chan_a) && $stable(converter_chan_b);
	endproperty
	property p_quiet_off;
		!en_q [*3] |-> !out_valid;
	endproperty
	property p_sum_equal;
		comb_q && out_valid |-> converter_chan_a == converter_chan_b;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	a_ready_answer: assert property (p_ready_answer) else $error("no pready after setup");
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
	a_out_hold: assert property (p_out_hold) else $error("words changed while stalled");
	a_quiet_off: assert property (p_quiet_off) else $error("output while disabled");
	a_sum_equal: assert property (p_sum_equal) else $error("summed channels differ");
	c_out: cover property (out_valid && out_ready);
	c_err: cover property (pslverr);
	c_full: cover property (osc_valid && !osc_ready);
endmodule : sog_output_stage_properties

//--- sog_dac_sink.sv
// converter sink and transmit enable driver at the stage's far side
`timescale 1ns/1ps
module sog_dac_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall,
	input wire logic [1:0] tx_req,
	input wire logic out_valid,
	input wire sog_pkg::sog_dac_word_type converter_chan_a,
	input wire sog_pkg::sog_dac_word_type converter_chan_b,
	output logic out_ready,
	output logic [1:0] transmit_enable,
	output int got_cnt,
	output sog_pkg::sog_dac_word_type last_a,
	output sog_pkg::sog_dac_word_type last_b
);
	import sog_pkg::*;
	// a slow core simply holds off words
	assign out_ready = !stall;
	// callers keep both bits equal whenever summing
	assign transmit_enable = tx_req;
	// last words start at zero so a check before any word arrives compares known values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			got_cnt <= 0;
			last_a <= 12'h000;
			last_b <= 12'h000;
		end
		else if (out_valid && out_ready)
		begin
			got_cnt <= got_cnt + 1;
			last_a <= converter_chan_a;
			last_b <= converter_chan_b;
		end
	end
endmodule : sog_dac_sink

//--- sog_output_stage_tb.sv
// self-checking bench for the synthesizer output stage
`timescale 1ns/1ps
module sog_output_stage_tb;
	import sog_pkg::*;
	localparam int DEPTH = 32;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, rdata, r1;
	logic pready, pslverr, rerr, osc_ready, out_valid, out_ready;
	logic osc_valid = 1'b0, stall = 1'b0;
	logic [1:0] transmit_enable;
	logic [1:0] tx_req = 2'h0;
	sog_sample_type osc_a_sample = 16'h0, osc_b_sample = 16'h0;
	sog_dac_word_type converter_chan_a, converter_chan_b, last_a, last_b;
	int got_cnt, n, c, k;
	int err_total = 0, total_checks = 0;
	always #20 pclk = ~pclk;
	sog_output_stage #(.FIFO_DEPTH(DEPTH)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .transmit_enable, .osc_a_sample, .osc_b_sample, .osc_valid, .osc_ready,
		.out_valid, .converter_chan_a, .converter_chan_b, .out_ready);
	sog_dac_sink u_sink (.pclk, .presetn, .stall, .tx_req, .out_valid, .converter_chan_a, .converter_chan_b,
		.out_ready, .transmit_enable, .got_cnt, .last_a, .last_b);
	task automatic test_done();
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			err_total++;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(rdata, e);
	endtask : rd
	// one sample in, waits for its words and checks both channels
	task automatic sample(input logic [15:0] a, input logic [15:0] b, input logic [11:0] ea, input logic [11:0] eb);
		n = got_cnt;
		@(posedge pclk);
		osc_a_sample <= a;
		osc_b_sample <= b;
		osc_valid <= 1'b1;
		// the sample stands until the stage takes it
		do
			@(posedge pclk);
		while (osc_ready !== 1'b1);
		osc_valid <= 1'b0;
		for (k = 0; k < 50 && got_cnt == n; k++)
			@(posedge pclk);
		cmp(32'(last_a), 32'(ea));
		cmp(32'(last_b), 32'(eb));
	endtask : sample
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(16'hCC0, 32'h0);
		rd(16'hCC4, 32'h2);
		rd(16'hCC8, 32'h3);
		rd(16'h0004, 32'h0);
		cmp(32'(rerr), 32'h1);
		apb(1'b1, 16'hCC0, 32'hFF);
		rd(16'hCC0, 32'h7);
		tx_req <= 2'h3;
		sample(16'h4000, 16'h1000, 12'h0, 12'h0);
		cmp(32'(got_cnt), 32'h0);
		tx_req <= 2'h0;
		apb(1'b1, 16'hCC8, 32'h8000);
		apb(1'b1, 16'hCC4, 32'h0);
		apb(1'b1, 16'hCC0, 32'h0);
		apb(1'b1, 16'hC20, 32'h1);
		tx_req <= 2'h2;
		apb(1'b1, 16'hCE0, 32'h1);
		rd(16'hCE4, 32'hE00400);
		tx_req <= 2'h0;
		apb(1'b1, 16'hCE0, 32'h3);
		sample(16'h4000, 16'hF000, 12'h200, 12'hF00);
		apb(1'b1, 16'hCE0, 32'h0);
		apb(1'b1, 16'hCC4, 32'h1);
		apb(1'b1, 16'hCE0, 32'h3);
		sample(16'h4000, 16'hF000, 12'h100, 12'h100);
		apb(1'b1, 16'hCE0, 32'h0);
		apb(1'b1, 16'hC20, 32'h0);
		apb(1'b1, 16'hCC8, 32'hFFFF);
		apb(1'b1, 16'hCC4, 32'h2);
		apb(1'b1, 16'hC20, 32'h1);
		apb(1'b1, 16'hCE0, 32'h3);
		sample(16'h4000, 16'h1000, 12'h0, 12'h100);
		// fill with the sink stalled, then drain
		stall <= 1'b1;
		osc_valid <= 1'b1;
		c = got_cnt;
		n = 0;
		repeat (40)
		begin
			@(posedge pclk);
			if (osc_ready === 1'b1)
				n++;
		end
		osc_valid <= 1'b0;
		stall <= 1'b0;
		cmp(32'(n), 32'(DEPTH + 1));
		for (k = 0; k < 200 && got_cnt != c + n; k++)
			@(posedge pclk);
		cmp(32'(got_cnt - c), 32'(n));
		// ramp slope per code, from two status reads three cycles apart
		for (c = 1; c < 8; c++)
		begin
			apb(1'b1, 16'hCE0, 32'h0);
			repeat (1100) @(posedge pclk);
			apb(1'b1, 16'hCC0, 32'(c));
			apb(1'b1, 16'hCE0, 32'h1);
			apb(1'b0, 16'hCE4, 32'h0);
			r1 = rdata;
			apb(1'b0, 16'hCE4, 32'h0);
			cmp(rdata - r1, 32'(3 << (7 - c)));
		end
		repeat (1100) @(posedge pclk);
		rd(16'hCE4, 32'h400400);
		apb(1'b1, 16'hCE0, 32'h0);
		repeat (100) @(posedge pclk);
		apb(1'b1, 16'hCE0, 32'h1);
		apb(1'b0, 16'hCE4, 32'h0);
		r1 = rdata;
		apb(1'b0, 16'hCE4, 32'h0);
		cmp(rdata - r1, 32'h3);
		test_done();
	end
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		test_done();
	end
endmodule : sog_output_stage_tb
bind sog_output_stage sog_output_stage_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .osc_valid, .osc_ready, .out_valid,
	.converter_chan_a, .converter_chan_b, .out_ready);
